// [logic/acs_pkg.sv]
`default_nettype none
package acs_pkg;
  // ---------------------------------------------------------------
  // Register map (word index = offset)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFF_CONTROL_ONE = 4'h0;
  localparam logic [3:0] OFF_CONTROL_TWO = 4'h1;
  localparam logic [3:0] OFF_CONTROL_FIVE = 4'h2;
  localparam logic [3:0] OFF_CHANNEL_SELECT = 4'h3;
  localparam logic [3:0] OFF_SCAN_LOW = 4'h4;
  localparam logic [3:0] OFF_SCAN_HIGH = 4'h5;
  localparam logic [3:0] OFF_TMU_EN_LOW = 4'h6;
  localparam logic [3:0] OFF_TMU_EN_HIGH = 4'h7;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_EVT_STATUS = 4'h9;
  localparam logic [3:0] OFF_EVT_MASK = 4'hA;
  localparam logic [3:0] OFF_SMP_PER_INT = 4'hB;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CON1_MODULE_ON = 15;
  localparam int CON1_SAMPLE_ACTIVE = 1;
  localparam int CON2_NEG_REF_CFG = 13;
  localparam int CON2_SCAN_ENABLE = 10;
  localparam int CON2_ALT_SETS_EN = 0;
  localparam int CON5_TMU_REQ = 13;
  localparam int CON5_BG_REQ = 12;
  localparam int CON5_REG_REQ = 11;
  localparam int CHS_POS_A_LSB = 0;
  localparam int CHS_NEG_A_LSB = 5;
  localparam int CHS_POS_B_LSB = 8;
  localparam int CHS_NEG_B_LSB = 13;
  // Event bits: 0 conversion start, 1 interrupt point reached
  localparam int EVT_CONV = 0;
  localparam int EVT_INT = 1;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [4:0] RST_SMP_PER_INT = 5'h00;
endpackage
`default_nettype wire

// [logic/acs_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer #(
  parameter int NCH = 32
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // Register port
  input wire logic [3:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [15:0] O_RDATA,
  // Conversion end from analog core
  input wire logic I_CONV_DONE,
  // Analog multiplexer controls
  output logic [4:0] O_POS_SEL,
  output logic [2:0] O_NEG_SEL,
  output logic O_NEG_REF_CFG,
  output logic O_SAMPLE,
  output logic O_CONV_START,
  output logic O_POWER_ON,
  output logic [NCH-1:0] O_TMU_ROUTE,
  output logic O_TMU_EN,
  output logic O_TMU_REQ,
  output logic O_BG_REQ,
  output logic O_REG_REQ,
  output logic O_IRQ
);
  // Scan and routing maps are fixed at 32 channels
  if (NCH != 32) begin : g_nch_check
    $error("NCH must be 32");
  end

  typedef struct packed {
    logic [15:0] con1;
    logic [15:0] con2;
    logic [15:0] con5;
    logic [15:0] chs;
    logic [31:0] scan;
    logic [31:0] tmu;
    logic [4:0] smp_per_int;
    logic [1:0] evt;
    logic [1:0] mask;
    logic use_b;
    logic [4:0] scan_ptr;
    logic [4:0] smp_cnt;
    logic [15:0] rdata;
    logic [4:0] pos;
    logic [2:0] neg;
    logic sample_active_q;
    logic conv;
    logic irq;
    logic pwr;
    logic nref;
    logic smp_out;
    logic [31:0] route;
    logic tmu_en;
    logic [2:0] req;
  } acs_state_s;

  acs_state_s st;
  acs_state_s next_st;

  // Lowest set bit at or above a start index; wraps to lowest overall
  function automatic logic [4:0] acs_next_ch(input logic [31:0] map, input logic [4:0] from);
    logic [4:0] r;
    logic found;
    r = 5'h00;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (map[i] && (5'(i) >= from)) begin
        r = 5'(i);
        found = 1'b1;
      end
    end
    if (!found) begin
      for (int i = 31; i >= 0; i--) begin
        if (map[i]) begin
          r = 5'(i);
        end
      end
    end
    return r;
  endfunction

  logic on;
  logic alt;
  logic scan_en;
  logic sample_active_fall;
  logic conv_end;
  logic int_point;
  logic [1:0] evt_set;
  logic [4:0] cur_scan;
  logic [15:0] rd_mux;

  always_comb begin
    on = st.con1[acs_pkg::CON1_MODULE_ON];
    alt = st.con2[acs_pkg::CON2_ALT_SETS_EN];
    scan_en = st.con2[acs_pkg::CON2_SCAN_ENABLE];
    cur_scan = acs_next_ch(st.scan, st.scan_ptr);
    sample_active_fall = on && st.sample_active_q && !st.con1[acs_pkg::CON1_SAMPLE_ACTIVE];
    conv_end = on && I_CONV_DONE;
    int_point = conv_end && (st.smp_cnt == st.smp_per_int);
    evt_set = {int_point, sample_active_fall};
    case (I_ADDR)
      acs_pkg::OFF_CONTROL_ONE: rd_mux = st.con1;
      acs_pkg::OFF_CONTROL_TWO: rd_mux = st.con2;
      acs_pkg::OFF_CONTROL_FIVE: rd_mux = st.con5;
      acs_pkg::OFF_CHANNEL_SELECT: rd_mux = st.chs;
      acs_pkg::OFF_SCAN_LOW: rd_mux = st.scan[15:0];
      acs_pkg::OFF_SCAN_HIGH: rd_mux = st.scan[31:16];
      acs_pkg::OFF_TMU_EN_LOW: rd_mux = st.tmu[15:0];
      acs_pkg::OFF_TMU_EN_HIGH: rd_mux = st.tmu[31:16];
      acs_pkg::OFF_STATUS: rd_mux = {st.use_b, st.scan_ptr, st.smp_cnt, st.pos};
      acs_pkg::OFF_EVT_STATUS: rd_mux = {14'h0000, st.evt};
      acs_pkg::OFF_EVT_MASK: rd_mux = {14'h0000, st.mask};
      acs_pkg::OFF_SMP_PER_INT: rd_mux = {11'h000, st.smp_per_int};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.rdata = I_RD ? rd_mux : 16'h0000;
    // -------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------
    if (I_WR) begin
      case (I_ADDR)
        acs_pkg::OFF_CONTROL_ONE: next_st.con1 = I_WDATA;
        acs_pkg::OFF_CONTROL_TWO: next_st.con2 = I_WDATA;
        acs_pkg::OFF_CONTROL_FIVE: next_st.con5 = I_WDATA;
        acs_pkg::OFF_CHANNEL_SELECT: next_st.chs = I_WDATA;
        acs_pkg::OFF_SCAN_LOW: next_st.scan[15:0] = I_WDATA;
        acs_pkg::OFF_SCAN_HIGH: next_st.scan[31:16] = I_WDATA;
        acs_pkg::OFF_TMU_EN_LOW: next_st.tmu[15:0] = I_WDATA;
        acs_pkg::OFF_TMU_EN_HIGH: next_st.tmu[31:16] = I_WDATA;
        acs_pkg::OFF_EVT_STATUS: next_st.evt = st.evt & ~I_WDATA[1:0];
        acs_pkg::OFF_EVT_MASK: next_st.mask = I_WDATA[1:0];
        acs_pkg::OFF_SMP_PER_INT: next_st.smp_per_int = I_WDATA[4:0];
        default: next_st.rdata = next_st.rdata;
      endcase
    end
    // Set wins over write-one clear
    next_st.evt = next_st.evt | evt_set;
    next_st.sample_active_q = on && st.con1[acs_pkg::CON1_SAMPLE_ACTIVE];
    next_st.conv = sample_active_fall;
    // -------------------------------------------------------------
    // Sequence progress
    // -------------------------------------------------------------
    if (conv_end) begin
      // Pointer moves on first-set samples only
      if (!st.use_b && scan_en) begin
        next_st.scan_ptr = cur_scan + 5'h01;
      end
      next_st.use_b = alt && !st.use_b;
      next_st.smp_cnt = st.smp_cnt + 5'h01;
      if (int_point) begin
        next_st.smp_cnt = 5'h00;
        next_st.scan_ptr = 5'h00;
        next_st.use_b = 1'b0;
      end
    end
    if (!alt) begin
      next_st.use_b = 1'b0;
    end
    // Sequencer parked when off, registers kept
    if (!on) begin
      next_st.smp_cnt = 5'h00;
      next_st.scan_ptr = 5'h00;
      next_st.use_b = 1'b0;
      next_st.conv = 1'b0;
    end
    // -------------------------------------------------------------
    // Input selection
    // -------------------------------------------------------------
    if (st.use_b) begin
      next_st.pos = st.chs[acs_pkg::CHS_POS_B_LSB +: 5];
      next_st.neg = st.chs[acs_pkg::CHS_NEG_B_LSB +: 3];
    end else begin
      next_st.pos = scan_en ? cur_scan : st.chs[acs_pkg::CHS_POS_A_LSB +: 5];
      next_st.neg = st.chs[acs_pkg::CHS_NEG_A_LSB +: 3];
    end
    next_st.irq = |(next_st.evt & st.mask);
    // -------------------------------------------------------------
    // Registered pin controls
    // -------------------------------------------------------------
    next_st.pwr = next_st.con1[acs_pkg::CON1_MODULE_ON];
    next_st.nref = next_st.con2[acs_pkg::CON2_NEG_REF_CFG];
    next_st.smp_out = next_st.pwr && next_st.con1[acs_pkg::CON1_SAMPLE_ACTIVE];
    next_st.route = next_st.pwr ? next_st.tmu : 32'h0000_0000;
    next_st.tmu_en = |next_st.route;
    if (next_st.pwr && next_st.con2[acs_pkg::CON2_SCAN_ENABLE]) begin
      next_st.req = {next_st.con5[acs_pkg::CON5_TMU_REQ], next_st.con5[acs_pkg::CON5_BG_REQ],
        next_st.con5[acs_pkg::CON5_REG_REQ]};
    end else begin
      next_st.req = 3'b000;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st <= '0;
      st.con1 <= acs_pkg::RST_REG;
      st.smp_per_int <= acs_pkg::RST_SMP_PER_INT;
    end else begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------
  assign O_RDATA = st.rdata;
  assign O_POS_SEL = st.pos;
  assign O_NEG_SEL = st.neg;
  assign O_NEG_REF_CFG = st.nref;
  assign O_SAMPLE = st.smp_out;
  assign O_CONV_START = st.conv;
  assign O_POWER_ON = st.pwr;
  assign O_TMU_ROUTE = st.route[NCH-1:0];
  assign O_TMU_EN = st.tmu_en;
  assign O_TMU_REQ = st.req[2];
  assign O_BG_REQ = st.req[1];
  assign O_REG_REQ = st.req[0];
  assign O_IRQ = st.irq;

  // -------------------------------------------------------------
  // Input selection checks
  // -------------------------------------------------------------
  // First-set positive
  chk_first_pos: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!st.use_b && !scan_en) |=> (O_POS_SEL == $past(st.chs[acs_pkg::CHS_POS_A_LSB +: 5])))
    else $error("first-set positive input not applied");

  chk_second_pos: assert property (@(posedge I_CLK) disable iff (I_RST)
    st.use_b |=> (O_POS_SEL == $past(st.chs[acs_pkg::CHS_POS_B_LSB +: 5])))
    else $error("second-set positive input not applied");

  chk_second_neg: assert property (@(posedge I_CLK) disable iff (I_RST)
    st.use_b |=> (O_NEG_SEL == $past(st.chs[acs_pkg::CHS_NEG_B_LSB +: 3])))
    else $error("second-set negative input not applied");

  chk_first_neg: assert property (@(posedge I_CLK) disable iff (I_RST)
    !st.use_b |=> (O_NEG_SEL == $past(st.chs[acs_pkg::CHS_NEG_A_LSB +: 3])))
    else $error("first-set negative input not applied");

  chk_scan_pos: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!st.use_b && scan_en) |=> (O_POS_SEL == $past(cur_scan)))
    else $error("scan channel not applied");

  chk_scan_member: assert property (@(posedge I_CLK) disable iff (I_RST)
    (scan_en && (st.scan != 32'h0000_0000)) |-> st.scan[cur_scan])
    else $error("scan pointer on unselected channel");

  // -------------------------------------------------------------
  // Sequencing checks
  // -------------------------------------------------------------
  // First set only
  chk_first_only: assert property (@(posedge I_CLK) disable iff (I_RST)
    !alt |=> !st.use_b)
    else $error("second set used without alternation");

  chk_alt_toggle: assert property (@(posedge I_CLK) disable iff (I_RST)
    (conv_end && alt && !int_point) |=> (st.use_b != $past(st.use_b)))
    else $error("set did not alternate");

  chk_ptr_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
    (conv_end && st.use_b && !int_point) |=> (st.scan_ptr == $past(st.scan_ptr)))
    else $error("scan pointer moved on second-set sample");

  chk_ptr_restart: assert property (@(posedge I_CLK) disable iff (I_RST)
    int_point |=> ((st.scan_ptr == 5'h00) && (st.smp_cnt == 5'h00) && !st.use_b))
    else $error("sequence not restarted at interrupt");

  chk_conv_start: assert property (@(posedge I_CLK) disable iff (I_RST)
    sample_active_fall |=> O_CONV_START)
    else $error("conversion not started at sample end");

  // -------------------------------------------------------------
  // Power and source checks
  // -------------------------------------------------------------
  // Parked while off
  chk_off_parked: assert property (@(posedge I_CLK) disable iff (I_RST)
    !on |=> (!O_CONV_START && (st.smp_cnt == 5'h00) && (st.scan_ptr == 5'h00)))
    else $error("sequencer active while off");

  chk_route_off: assert property (@(posedge I_CLK) disable iff (I_RST)
    !O_POWER_ON |-> (O_TMU_ROUTE == 32'h0000_0000))
    else $error("timing unit routed while off");

  chk_tmu_enable: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_TMU_EN == (O_TMU_ROUTE != 32'h0000_0000))
    else $error("timing unit enable does not follow routing");

  chk_req_scan: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_TMU_REQ || O_BG_REQ || O_REG_REQ) |-> (on && scan_en))
    else $error("internal source requested outside scan");

endmodule // acs_sequencer
`default_nettype wire

// [dv/acs_mux_model.sv]
`timescale 1ns/100ps
`default_nettype none
module acs_mux_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Sequencer side
  input wire logic i_start,
  input wire logic i_slow,
  input wire logic [4:0] i_pos,
  input wire logic [2:0] i_neg,
  input wire logic [2:0] i_req,
  // Conversion end and captured selection
  output logic o_done,
  output logic [4:0] o_pos,
  output logic [2:0] o_neg,
  output logic [2:0] o_req
);
  logic [3:0] t;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      t <= 4'h0;
      o_done <= 1'b0;
      o_pos <= 5'h00;
      o_neg <= 3'h0;
      o_req <= 3'h0;
    end else begin
      o_done <= (t == 4'h1);
      if (t != 4'h0) begin
        t <= t - 4'h1;
      end
      if (i_start) begin
        t <= i_slow ? 4'h9 : 4'h1;
        o_pos <= i_pos;
        o_neg <= i_neg;
        o_req <= i_req;
      end
    end
  end
endmodule // acs_mux_model
`default_nettype wire

// [dv/acs_sequencer_test.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; $display("Error t=%0t got %h exp %h", $time, a, e); end end
module acs_sequencer_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow = 1'b0;
  logic [15:0] rdata;
  logic [4:0] pos, mpos;
  logic [2:0] neg, mneg, mreq;
  wire [2:0] req;
  logic [31:0] route;
  logic done, nref, sample_active, cst, pwr, tmu_en, irq;
  int num_errors = 0;
  int check_count = 0;
  always #10 clk = ~clk;
  acs_sequencer i_dut (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_CONV_DONE(done), .O_POS_SEL(pos), .O_NEG_SEL(neg), .O_NEG_REF_CFG(nref),
    .O_SAMPLE(sample_active), .O_CONV_START(cst), .O_POWER_ON(pwr), .O_TMU_ROUTE(route), .O_TMU_EN(tmu_en),
    .O_TMU_REQ(req[2]), .O_BG_REQ(req[1]), .O_REG_REQ(req[0]), .O_IRQ(irq));
  acs_mux_model i_mux (.i_clk(clk), .i_rst(rst), .i_start(cst), .i_slow(slow), .i_pos(pos), .i_neg(neg),
    .i_req(req), .o_done(done), .o_pos(mpos), .o_neg(mneg), .o_req(mreq));
  task automatic results();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic conv();
    int i;
    wr_reg(acs_pkg::OFF_CONTROL_ONE, 16'h8002);
    repeat (3) @(posedge clk);
    #1 `CHK(sample_active, 1'b1)
    wr_reg(acs_pkg::OFF_CONTROL_ONE, 16'h8000);
    for (i = 0; i < 40 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 40) begin
      num_errors++;
      results();
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic t_regs();
    logic [15:0] d;
    wr_reg(4'hF, 16'hFFFF);
    for (int a = 0; a < 16; a++) begin
      rd_reg(4'(a), d);
      if (a != 8) `CHK(d, acs_pkg::RST_REG)
    end
    wr_reg(acs_pkg::OFF_CHANNEL_SELECT, 16'hB166);
    wr_reg(acs_pkg::OFF_CONTROL_FIVE, 16'h3800);
    rd_reg(acs_pkg::OFF_CHANNEL_SELECT, d);
    `CHK(d, 16'hB166)
    $display("regs done");
  endtask
  task automatic seq(input logic [15:0] c2, n, sl, sh, input logic [19:0] ep, input logic [11:0] en);
    wr_reg(acs_pkg::OFF_CONTROL_ONE, 16'h0000);
    wr_reg(acs_pkg::OFF_CONTROL_TWO, c2);
    wr_reg(acs_pkg::OFF_SMP_PER_INT, n);
    wr_reg(acs_pkg::OFF_SCAN_LOW, sl);
    wr_reg(acs_pkg::OFF_SCAN_HIGH, sh);
    wr_reg(acs_pkg::OFF_CONTROL_ONE, 16'h8000);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      conv();
      `CHK(mpos, ep[i*5+:5])
      `CHK(mneg, en[i*3+:3])
      `CHK(mreq, c2[10] ? 3'b111 : 3'b000)
    end
    $display("seq %h done", c2);
  endtask
  task automatic t_irq();
    logic [15:0] d;
    rd_reg(acs_pkg::OFF_EVT_STATUS, d);
    `CHK(d[1:0], 2'b11)
    wr_reg(acs_pkg::OFF_EVT_MASK, 16'h0000);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'b0)
    wr_reg(acs_pkg::OFF_EVT_MASK, 16'h0003);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'b1)
    wr_reg(acs_pkg::OFF_EVT_STATUS, 16'h0003);
    rd_reg(acs_pkg::OFF_EVT_STATUS, d);
    `CHK({d[1:0], irq}, 3'b000)
    $display("irq done");
  endtask
  task automatic t_misc();
    logic [15:0] d;
    wr_reg(acs_pkg::OFF_TMU_EN_LOW, 16'h0010);
    wr_reg(acs_pkg::OFF_TMU_EN_HIGH, 16'h8000);
    wr_reg(acs_pkg::OFF_CONTROL_TWO, 16'h2000);
    #1 `CHK({route, tmu_en}, {32'h8000_0010, 1'b1})
    `CHK(nref, 1'b1)
    wr_reg(acs_pkg::OFF_CONTROL_ONE, 16'h0000);
    rd_reg(acs_pkg::OFF_CHANNEL_SELECT, d);
    `CHK({pwr, route, d}, {1'b0, 32'h0000_0000, 16'hB166})
    wr_reg(acs_pkg::OFF_CONTROL_ONE, 16'h8000);
    #1 `CHK(pwr, 1'b1)
    $display("misc done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    seq(16'h0000, 0, 0, 0, {4{5'd6}}, {4{3'd3}});
    seq(16'h0001, 1, 0, 0, {5'd17, 5'd6, 5'd17, 5'd6}, {3'd5, 3'd3, 3'd5, 3'd3});
    slow <= 1'b1;
    seq(16'h0400, 1, 16'h0010, 16'h0004, {5'd18, 5'd4, 5'd18, 5'd4}, {4{3'd3}});
    seq(16'h0400, 1, 16'h0014, 16'h0004, {5'd4, 5'd2, 5'd4, 5'd2}, {4{3'd3}});
    seq(16'h0401, 3, 16'h0014, 16'h0004, {5'd17, 5'd4, 5'd17, 5'd2}, {3'd5, 3'd3, 3'd5, 3'd3});
    t_irq();
    t_misc();
    results();
  end
endmodule // acs_sequencer_test
`default_nettype wire
